// >>> pkg/cmd_parser_defs.svh
// Constants for the ASCII command parser: indexes, characters, reset values
`ifndef CMD_PARSER_DEFS_SVH
`define CMD_PARSER_DEFS_SVH

`define CHR_START        8'h21
`define CHR_COMMA        8'h2c
`define CHR_CR           8'h0d
`define CHR_LF           8'h0a
`define CHR_SPACE        8'h20
`define CHR_COLON        8'h3a
`define CHR_Y            8'h59
`define CHR_N            8'h4e
`define CHR_D            8'h44
`define CHR_M            8'h4d
`define CHR_W            8'h57
`define CHR_R            8'h52
`define CHR_ZERO         8'h30
`define ADDR_DEFAULT     8'h11
`define ADDR_BROADCAST   8'h00
`define IDX_STATION_ADDR 16'h0007
`define IDX_VOLT_SCALE   16'h0019
`define IDX_CUR_SCALE    16'h001b
`define IDX_CUR_OFFSET   16'h001c
`define IDX_PRIV_GATE    16'h03e8
`define CH_DAC_RAW       16'h0001
`define CH_FREEZE        16'h0004
`define SCALE_RESET      16'h0000
`define OFFSET_RESET     16'h0000

`endif

// >>> pkg/cmd_parser_pkg.sv
// Types shared by the command parser and its reply formatter
package cmd_parser_pkg;
  typedef enum logic [2:0] {
    REPLY_NONE,
    REPLY_VALUE,
    REPLY_PRIV,
    REPLY_FREEZE
  } reply_kind_t;
endpackage : cmd_parser_pkg

// >>> pkg/reply_if.sv
// Reply request from parser to reply formatter
`timescale 1ns/1ps
interface reply_if;
  logic                      start;
  logic                      busy;
  cmd_parser_pkg::reply_kind_t kind;
  logic [7:0]                addr;
  logic                      with_addr;
  logic [15:0]               value;
  logic [7:0]                flag_chr;
  modport parser (output start, output kind, output addr, output with_addr,
                  output value, output flag_chr, input busy);
  modport formatter (input start, input kind, input addr, input with_addr,
                     input value, input flag_chr, output busy);
endinterface : reply_if

// >>> hw/reply_formatter.sv
// Serialises an ASCII reply frame one character at a time
`include "cmd_parser_defs.svh"
`timescale 1ns/1ps
module reply_formatter (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Request from the parser
  reply_if.formatter      rq,
  // Character output
  output logic      [7:0] tx_data,
  output logic            tx_valid,
  input  wire logic       tx_ready
);
  logic [4:0]  pos_q;
  logic [4:0]  len_q;
  logic [7:0]  buf_q [0:23];
  logic        act_q;

  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_chr

  assign rq.busy  = act_q;
  assign tx_valid = act_q;
  assign tx_data  = buf_q[pos_q];

  // Build the whole frame at start so serialising stays a plain index walk
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      act_q <= 1'b0;
      pos_q <= 5'd0;
      len_q <= 5'd0;
      for (int i = 0; i < 24; i++) buf_q[i] <= 8'h00;
    end
    else if (!act_q && rq.start)
    begin
      logic [4:0]  n;
      logic [7:0]  s [0:15];
      n = 5'd0;
      for (int i = 0; i < 16; i++) s[i] = 8'h00;
      if (rq.with_addr)
      begin
        buf_q[0] <= `CHR_START;
        buf_q[1] <= hex_chr(rq.addr[7:4]);
        buf_q[2] <= hex_chr(rq.addr[3:0]);
        buf_q[3] <= `CHR_COMMA;
        n = 5'd4;
      end
      case (rq.kind)
        cmd_parser_pkg::REPLY_PRIV:
        begin
          // BackDoorEnabled: Y or N
          s = '{8'h42,8'h61,8'h63,8'h6b,8'h44,8'h6f,8'h6f,8'h72,
                8'h45,8'h6e,8'h61,8'h62,8'h6c,8'h65,8'h64,`CHR_COLON};
          for (int i = 0; i < 16; i++) buf_q[n + 5'(i)] <= s[i];
          buf_q[n + 5'd16] <= `CHR_SPACE;
          buf_q[n + 5'd17] <= rq.flag_chr;
          buf_q[n + 5'd18] <= `CHR_CR;
          len_q <= n + 5'd19;
        end
        cmd_parser_pkg::REPLY_FREEZE:
        begin
          s = '{8'h44,8'h69,8'h73,8'h61,8'h62,8'h6c,8'h65,8'h55,
                8'h70,8'h64,8'h61,8'h74,8'h65,`CHR_COLON,`CHR_SPACE,8'h00};
          for (int i = 0; i < 15; i++) buf_q[n + 5'(i)] <= s[i];
          buf_q[n + 5'd15] <= rq.flag_chr;
          buf_q[n + 5'd16] <= `CHR_CR;
          len_q <= n + 5'd17;
        end
        default:
        begin
          // Values go out as four hex digits, printable only
          buf_q[n]        <= hex_chr(rq.value[15:12]);
          buf_q[n + 5'd1] <= hex_chr(rq.value[11:8]);
          buf_q[n + 5'd2] <= hex_chr(rq.value[7:4]);
          buf_q[n + 5'd3] <= hex_chr(rq.value[3:0]);
          buf_q[n + 5'd4] <= `CHR_CR;
          len_q <= n + 5'd5;
        end
      endcase
      pos_q <= 5'd0;
      act_q <= 1'b1;
    end
    else if (act_q && tx_ready)
    begin
      if (pos_q + 5'd1 == len_q)
        act_q <= 1'b0;
      pos_q <= pos_q + 5'd1;
    end
  end

  AST_PRINTABLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    tx_valid |-> (tx_data == `CHR_CR || (tx_data >= 8'h20 && tx_data < 8'h7f)))
    else $error("non printable reply character");
endmodule : reply_formatter

// >>> hw/ascii_cmd_parser.sv
// Addressed ASCII command frame parser with calibration store and DAC control
`include "cmd_parser_defs.svh"
`timescale 1ns/1ps
module ascii_cmd_parser #(
  parameter int DAC_W = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Configuration
  input  wire logic             p2p_mode,
  // Received characters
  input  wire logic [7:0]       rx_data,
  input  wire logic             rx_valid,
  // Reply characters
  output logic      [7:0]       tx_data,
  output logic                  tx_valid,
  input  wire logic             tx_ready,
  // Flow-derived output code and DAC
  input  wire logic [DAC_W-1:0] auto_code,
  output logic      [DAC_W-1:0] dac_code,
  // Calibration values and state
  output logic      [15:0]      voltage_output_scale,
  output logic      [15:0]      current_output_scale,
  output logic      [15:0]      current_output_offset,
  output logic                  privileged_access_gate,
  output logic                  dac_frozen,
  output logic      [7:0]       station_addr
);
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR_HI, S_ADDR_LO, S_ADDR_SEP, S_BODY, S_SKIP
  } pstate_t;

  pstate_t     st_q;
  logic [7:0]  addr_q;
  logic [15:0] cmd_q;
  logic [1:0]  cmd_len_q;
  logic [2:0]  field_q;
  logic [15:0] arg1_q;
  logic [15:0] arg2_q;
  logic [7:0]  arg2_chr_q;
  logic        arg_bad_q;
  logic        exec_q;
  logic [15:0] vscale_q;
  logic [15:0] cscale_q;
  logic [15:0] coffs_q;
  logic        gate_q;
  logic        frozen_q;
  logic [DAC_W-1:0] raw_q;
  logic [DAC_W-1:0] dac_q;
  logic [7:0]  station_q;

  reply_if rq ();

  function automatic logic is_hex(input logic [7:0] c);
    is_hex = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
          || (c >= 8'h61 && c <= 8'h66);
  endfunction : is_hex

  function automatic logic [3:0] hex_val(input logic [7:0] c);
    if (c <= 8'h39) hex_val = c[3:0];
    else            hex_val = c[3:0] + 4'h9;
  endfunction : hex_val

  // Accumulate decimal digits; hex addresses come through hex_val instead
  function automatic logic [15:0] dec_acc(input logic [15:0] v, input logic [7:0] c);
    dec_acc = 16'((v << 3) + (v << 1) + {8'h00, c - `CHR_ZERO});
  endfunction : dec_acc

  wire is_digit = rx_data >= 8'h30 && rx_data <= 8'h39;

  // Character parser; '!' restarts outside point-to-point mode so a garbled frame cannot wedge it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_q       <= S_IDLE;
      addr_q     <= 8'h00;
      cmd_q      <= 16'h0000;
      cmd_len_q  <= 2'd0;
      field_q    <= 3'd0;
      arg1_q     <= 16'h0000;
      arg2_q     <= 16'h0000;
      arg2_chr_q <= 8'h00;
      arg_bad_q  <= 1'b0;
      exec_q     <= 1'b0;
    end
    else
    begin
      exec_q <= 1'b0;
      if (rx_valid && rx_data != `CHR_LF)
      begin
        if (rx_data == `CHR_START && !p2p_mode)
        begin
          st_q <= S_ADDR_HI;
        end
        else
        begin
          case (st_q)
            S_IDLE:
            begin
              // Point-to-point frames open straight on the command field
              if (p2p_mode && rx_data != `CHR_CR)
              begin
                addr_q    <= station_q;
                cmd_q     <= {8'h00, rx_data};
                cmd_len_q <= 2'd1;
                field_q   <= 3'd0;
                arg1_q    <= 16'h0000;
                arg2_q    <= 16'h0000;
                arg_bad_q <= 1'b0;
                st_q      <= S_BODY;
              end
            end
            S_ADDR_HI:
              if (is_hex(rx_data))
              begin
                addr_q[7:4] <= hex_val(rx_data);
                st_q        <= S_ADDR_LO;
              end
              else
                st_q <= S_SKIP;
            S_ADDR_LO:
              if (is_hex(rx_data))
              begin
                addr_q[3:0] <= hex_val(rx_data);
                st_q        <= S_ADDR_SEP;
              end
              else
                st_q <= S_SKIP;
            S_ADDR_SEP:
            begin
              cmd_q     <= 16'h0000;
              cmd_len_q <= 2'd0;
              field_q   <= 3'd0;
              arg1_q    <= 16'h0000;
              arg2_q    <= 16'h0000;
              arg_bad_q <= 1'b0;
              // Foreign address: drop the rest of the frame quietly
              if (rx_data != `CHR_COMMA ||
                  (addr_q != station_q && addr_q != `ADDR_BROADCAST))
                st_q <= S_SKIP;
              else
                st_q <= S_BODY;
            end
            S_BODY:
            begin
              if (rx_data == `CHR_CR)
              begin
                exec_q <= 1'b1;
                st_q   <= S_IDLE;
              end
              else if (rx_data == `CHR_COMMA)
              begin
                if (field_q == 3'd4)
                  st_q <= S_SKIP;
                field_q <= field_q + 3'd1;
              end
              else if (field_q == 3'd0)
              begin
                if (cmd_len_q < 2'd2)
                begin
                  cmd_q     <= {cmd_q[7:0], rx_data};
                  cmd_len_q <= cmd_len_q + 2'd1;
                end
              end
              else if (field_q == 3'd1)
              begin
                if (is_digit) arg1_q <= dec_acc(arg1_q, rx_data);
                else          arg_bad_q <= 1'b1;
              end
              else if (field_q == 3'd2)
              begin
                arg2_chr_q <= rx_data;
                if (is_digit) arg2_q <= dec_acc(arg2_q, rx_data);
                else          arg_bad_q <= 1'b1;
              end
            end
            S_SKIP:
              if (rx_data == `CHR_CR)
                st_q <= S_IDLE;
            default:
              st_q <= S_IDLE;
          endcase
        end
      end
    end
  end

  wire cmd_mw    = cmd_q == {`CHR_M, `CHR_W};
  wire cmd_mr    = cmd_q == {`CHR_M, `CHR_R};
  wire cmd_wr    = cmd_q[15:8] == 8'h00 && cmd_q[7:0] == `CHR_W;
  wire broadcast = !p2p_mode && addr_q == `ADDR_BROADCAST;

  // Calibration store and gates; writes land one cycle after the CR that closes the frame
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      vscale_q  <= `SCALE_RESET;
      cscale_q  <= `SCALE_RESET;
      coffs_q   <= `OFFSET_RESET;
      gate_q    <= 1'b0;
      frozen_q  <= 1'b0;
      raw_q     <= '0;
      station_q <= `ADDR_DEFAULT;
    end
    else if (exec_q && cmd_mw)
    begin
      case (arg1_q)
        `IDX_VOLT_SCALE:   vscale_q <= arg2_q;
        `IDX_CUR_SCALE:    cscale_q <= arg2_q;
        `IDX_CUR_OFFSET:   coffs_q  <= arg2_q;
        `IDX_PRIV_GATE:    if (arg2_q <= 16'h0001) gate_q <= arg2_q[0];
        `IDX_STATION_ADDR: if (arg2_q[7:0] != `ADDR_BROADCAST) station_q <= arg2_q[7:0];
        default:           ;
      endcase
    end
    else if (exec_q && cmd_wr)
    begin
      if (arg1_q == `CH_FREEZE && arg2_chr_q == `CHR_D)
        frozen_q <= 1'b1;
      else if (arg1_q == `CH_FREEZE && arg2_chr_q == `CHR_N)
        frozen_q <= 1'b0;
      else if (arg1_q == `CH_DAC_RAW && !arg_bad_q)
        raw_q <= DAC_W'(arg2_q);
    end
  end

  // DAC register: frozen holds raw count, otherwise follows the flow code
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      dac_q <= '0;
    else if (frozen_q)
      dac_q <= raw_q;
    else
      dac_q <= auto_code;
  end

  // Memory read value
  logic [15:0] rd_val;
  always_comb
  begin
    case (arg1_q)
      `IDX_VOLT_SCALE:   rd_val = vscale_q;
      `IDX_CUR_SCALE:    rd_val = cscale_q;
      `IDX_CUR_OFFSET:   rd_val = coffs_q;
      `IDX_PRIV_GATE:    rd_val = {15'h0000, gate_q};
      `IDX_STATION_ADDR: rd_val = {8'h00, station_q};
      default:           rd_val = 16'h0000;
    endcase
  end

  // Reply request; broadcasts execute silently
  always_comb
  begin
    rq.kind     = cmd_parser_pkg::REPLY_NONE;
    rq.flag_chr = `CHR_N;
    if (cmd_mr)
      rq.kind = cmd_parser_pkg::REPLY_VALUE;
    else if (cmd_mw && arg1_q == `IDX_PRIV_GATE && arg2_q <= 16'h0001)
    begin
      rq.kind     = cmd_parser_pkg::REPLY_PRIV;
      rq.flag_chr = arg2_q[0] ? `CHR_Y : `CHR_N;
    end
    else if (cmd_wr && arg1_q == `CH_FREEZE &&
             (arg2_chr_q == `CHR_D || arg2_chr_q == `CHR_N))
    begin
      rq.kind     = cmd_parser_pkg::REPLY_FREEZE;
      rq.flag_chr = arg2_chr_q;
    end
  end

  assign rq.start     = exec_q && !broadcast && rq.kind != cmd_parser_pkg::REPLY_NONE;
  assign rq.addr      = station_q;
  assign rq.with_addr = !p2p_mode;
  assign rq.value     = rd_val;

  reply_formatter u_fmt (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .rq       (rq.formatter),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready)
  );

  assign voltage_output_scale   = vscale_q;
  assign current_output_scale   = cscale_q;
  assign current_output_offset  = coffs_q;
  assign privileged_access_gate = gate_q;
  assign dac_frozen             = frozen_q;
  assign dac_code               = dac_q;
  assign station_addr           = station_q;

  AST_START_RESTARTS: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_valid && rx_data == `CHR_START && !p2p_mode |=> st_q == S_ADDR_HI)
    else $error("start character did not restart frame");
  AST_LF_IGNORED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_valid && rx_data == `CHR_LF |=> $stable(st_q) && !exec_q)
    else $error("line feed changed parser state");
  AST_BAD_HEX: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rx_valid && st_q == S_ADDR_HI && !is_hex(rx_data) && rx_data != `CHR_START
    && rx_data != `CHR_LF |=> st_q == S_SKIP)
    else $error("bad hex address accepted");
  AST_GATE_OPEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_q && cmd_mw && arg1_q == `IDX_PRIV_GATE && arg2_q == 16'h0001
    |=> privileged_access_gate)
    else $error("gate not opened");
  AST_GATE_CLOSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_q && cmd_mw && arg1_q == `IDX_PRIV_GATE && arg2_q == 16'h0000
    |=> !privileged_access_gate)
    else $error("gate not closed");
  AST_FREEZE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_q && cmd_wr && arg1_q == `CH_FREEZE && arg2_chr_q == `CHR_D
    |=> dac_frozen ##1 dac_code == raw_q)
    else $error("freeze not applied");
  AST_RESUME: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_q && cmd_wr && arg1_q == `CH_FREEZE && arg2_chr_q == `CHR_N
    |=> !dac_frozen)
    else $error("resume not applied");
  AST_BROADCAST_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_q && broadcast |-> !rq.start)
    else $error("broadcast acknowledged");
  AST_STORE_SCALE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    exec_q && cmd_mw && arg1_q == `IDX_CUR_SCALE |=> current_output_scale == $past(arg2_q))
    else $error("current scale not stored");
endmodule : ascii_cmd_parser

// >>> dv/serial_host_model.sv
// Host-side model: takes reply characters from the parser, optionally stalling
`timescale 1ns/1ps
module serial_host_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Reply stream from the device
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  // Pacing control
  input  wire logic       slow
);
  logic [1:0] pace_q;
  logic [7:0] got_q [$];

  initial tx_ready = 1'b0;

  // A slow host accepts one char in three, so the device must hold each char
  always @(posedge ref_clk)
  begin
    pace_q <= (!rst_n || pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
    #1;
    tx_ready = rst_n && (!slow || pace_q == 2'h0);
  end

  // Collect each char at the edge where it is offered and accepted
  always @(posedge ref_clk)
  begin
    if (rst_n && tx_valid === 1'b1 && tx_ready === 1'b1)
      got_q.push_back(tx_data);
  end
endmodule : serial_host_model

// >>> dv/test_ascii_serial_command_parser.sv
// Self-checking bench for the ASCII command parser driven as a host would
`include "cmd_parser_defs.svh"
`timescale 1ns/1ps
module test_ascii_serial_command_parser;
  logic        ref_clk;
  logic        rst_n;
  logic        p2p_mode;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic        slow;
  logic [15:0] auto_code;
  logic [15:0] dac_code;
  logic [15:0] volt_scale;
  logic [15:0] cur_scale;
  logic [15:0] cur_offset;
  logic        gate;
  logic        frozen;
  logic [7:0]  station;
  int          failures;
  int          total_checks;
  int          start;
  string       idx [3] = '{"25", "27", "28"};
  string       val [3] = '{"1234", "250", "1000"};
  string       hex [3] = '{"04D2", "00FA", "03E8"};
  string       bad [3] = '{"!12,MW,25,9\r", "!1G,MW,25,9\r", "!Z1,MW,25,9\r"};

  // Device under test
  ascii_cmd_parser uut (
    .ref_clk                (ref_clk),
    .rst_n                  (rst_n),
    .p2p_mode               (p2p_mode),
    .rx_data                (rx_data),
    .rx_valid               (rx_valid),
    .tx_data                (tx_data),
    .tx_valid               (tx_valid),
    .tx_ready               (tx_ready),
    .auto_code              (auto_code),
    .dac_code               (dac_code),
    .voltage_output_scale   (volt_scale),
    .current_output_scale   (cur_scale),
    .current_output_offset  (cur_offset),
    .privileged_access_gate (gate),
    .dac_frozen             (frozen),
    .station_addr           (station)
  );

  // Far-side host taking the replies
  serial_host_model host (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .tx_data  (tx_data),
    .tx_valid (tx_valid),
    .tx_ready (tx_ready),
    .slow     (slow)
  );

  // 250 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    if (failures == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Wait until the reply line has been quiet long enough; bounded
  task automatic settle();
    int idle;
    idle = 0;
    for (int n = 0; n < 3000 && idle < 60; n++)
    begin
      @(posedge ref_clk);
      #1;
      idle = (tx_valid === 1'b0) ? idle + 1 : 0;
    end
    if (idle < 60)
    begin
      failures++;
      $display("[ERR] reply idle cycles expected 60 seen %0d", idle);
      close_out();
    end
  endtask : settle

  // Send a frame back to back, one char per edge, then let any reply finish
  task automatic run(string s);
    start = host.got_q.size();
    for (int i = 0; i < s.len(); i++)
    begin
      rx_data  = s[i];
      rx_valid = 1'b1;
      @(posedge ref_clk);
      #1;
    end
    rx_valid = 1'b0;
    settle();
  endtask : run

  // Compare the reply taken since the last frame against head, tail and length
  task automatic check_reply(string head, string tail, int len);
    string s;
    logic  ok;
    s = "";
    for (int i = start; i < host.got_q.size(); i++)
    begin
      s  = {s, string'(host.got_q[i])};
      ok = (host.got_q[i] >= 8'h20 && host.got_q[i] <= 8'h7e) || host.got_q[i] === `CHR_CR;
      chk("reply char printable", 16'h1, {15'h0, ok});
    end
    total_checks++;
    if (s.len() != len || s.substr(0, head.len() - 1) != head ||
        s.substr(len - tail.len(), len - 1) != tail)
    begin
      failures++;
      $display("[ERR] reply expected %s..%s seen %s", head, tail, s);
    end
  endtask : check_reply

  // Main sequence
  initial
  begin
    failures     = 0;
    total_checks = 0;
    start        = 0;
    rst_n        = 1'b0;
    p2p_mode     = 1'b0;
    rx_data      = 8'h00;
    rx_valid     = 1'b0;
    slow         = 1'b0;
    auto_code    = 16'h0123;
    repeat (10) @(posedge ref_clk);
    #1;
    chk("station_addr", 16'(`ADDR_DEFAULT), 16'(station));
    chk("voltage scale reset", `SCALE_RESET, volt_scale);
    chk("current scale reset", `SCALE_RESET, cur_scale);
    chk("current offset reset", `OFFSET_RESET, cur_offset);
    chk("gate reset", 16'h0, 16'(gate));
    chk("frozen reset", 16'h0, 16'(frozen));
    chk("dac reset", 16'h0, dac_code);
    rst_n = 1'b1;
    // Open access; the line feed inside the frame must be dropped
    run("!11,MW,10\n00,1\r");
    chk("gate open", 16'h1, 16'(gate));
    check_reply("!11,", ": Y\r", 23);
    // Write and read back each calibration index with a stalling host
    slow = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      run({"!11,MW,", idx[i], ",", val[i], "\r"});
      run({"!11,MR,", idx[i], "\r"});
      check_reply({"!11,", hex[i], "\r"}, "", 9);
    end
    slow = 1'b0;
    chk("voltage scale", 16'd1234, volt_scale);
    chk("current scale", 16'd250, cur_scale);
    chk("current offset", 16'd1000, cur_offset);
    // A start char in mid-frame throws away the partial frame
    run("!11,MW,25!11,MW,25,77\r");
    chk("restarted frame", 16'd77, volt_scale);
    // A foreign address and two malformed addresses are ignored silently
    for (int i = 0; i < 3; i++)
    begin
      run(bad[i]);
      chk("foreign reply count", 16'h0, 16'(host.got_q.size() - start));
      chk("foreign no store", 16'd77, volt_scale);
    end
    // Broadcast executes without a reply
    run("!00,MW,25,500\r");
    chk("broadcast store", 16'd500, volt_scale);
    chk("broadcast reply count", 16'h0, 16'(host.got_q.size() - start));
    // Point-to-point frame starts at the command field
    p2p_mode = 1'b1;
    run("MW,25,321\r");
    chk("p2p store", 16'd321, volt_scale);
    // Point-to-point replies carry neither start char nor address
    run("MR,25\r");
    check_reply("0141\r", "", 5);
    p2p_mode = 1'b0;
    // Freeze the DAC, then load raw counts with the auto code moved to 0abc
    auto_code = 16'h0abc;
    run("!11,W,4,D\r");
    chk("frozen", 16'h1, 16'(frozen));
    check_reply("!11,", ": D\r", 21);
    run("!11,W,1,4000\r");
    chk("dac raw 4000", 16'd4000, dac_code);
    run("!11,W,1,0\r");
    chk("dac raw zero", 16'h0, dac_code);
    // Resume updating and close access
    run("!11,W,4,N\r");
    chk("resumed", 16'h0, 16'(frozen));
    check_reply("!11,", ": N\r", 21);
    chk("dac follows auto", 16'h0abc, dac_code);
    run("!11,MW,1000,0\r");
    chk("gate closed", 16'h0, 16'(gate));
    check_reply("!11,", ": N\r", 23);
    // Broadcast write of index 7 moves the station; the new address answers
    run("!00,MW,7,18\r");
    chk("station moved", 16'h0012, 16'(station));
    run("!12,MR,25\r");
    check_reply("!12,0141\r", "", 9);
    close_out();
  end
endmodule : test_ascii_serial_command_parser
